// File: hw/fbms_consts.svh
`ifndef FBMS_CONSTS_SVH
`define FBMS_CONSTS_SVH

// ==========================================================
// register word indices (byte address is four times these)
`define FBMS_IDX_STATUS_LO 14'h840
`define FBMS_IDX_STATUS_HI 14'h844
`define FBMS_IDX_IN_TAB_LO 14'h850
`define FBMS_IDX_OUT_TAB_LO 14'h88c
`define FBMS_IDX_TAB_HI 14'h8c7
`define FBMS_IDX_MODE 14'h8ce

// ==========================================================
// station table shape
`define FBMS_STATIONS 60
`define FBMS_STATUS_WORDS 5
`define FBMS_OUT_AREA_BASE 16'h03c0
`define FBMS_NORMAL_AREA_BYTES 8'h20

// ==========================================================
// operating mode codes, low nibble of the mode word
`define FBMS_MODE_NORMAL 4'h0
`define FBMS_MODE_PARAM 4'h1
`define FBMS_MODE_SELFDIAG 4'h2
`define FBMS_MODE_EXTENDED 4'he

// ==========================================================
// mode word high byte: how the mode was selected
`define FBMS_SRC_HOST 8'h00
`define FBMS_SRC_NVMEM 8'h01
`define FBMS_SRC_SWITCH 8'h10
`define FBMS_MODE_WORD_RESET 16'h0000

`endif

// File: hw/fbms_pkg.sv
package fbms_pkg;

  // configured slave parameters of one station
  typedef struct packed {
    logic present;
    logic [7:0] in_len;
    logic [7:0] out_len;
  } fbms_cfg_t;

  // one apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } fbms_apb_req_t;

  // one start-address table write from the allocator
  typedef struct packed {
    logic wr;
    logic [5:0] idx;
    logic [15:0] in_addr;
    logic [15:0] out_addr;
  } fbms_tab_wr_t;

endpackage

// File: hw/fbms_apb_slave.sv
`timescale 1ns/1ps
`include "fbms_consts.svh"

module fbms_apb_slave (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // apb
  input fbms_pkg::fbms_apb_req_t i_apb,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // register file side
  output logic [13:0] o_word_idx,
  input wire logic [15:0] i_rd_data,
  input wire logic i_hit
);
  import fbms_pkg::*;

  logic [31:0] prdata_r;
  logic err_r;
  logic setup;

  assign setup = i_apb.psel && !i_apb.penable;
  assign o_word_idx = i_apb.paddr[15:2];

  // ==========================================================
  // read data and error are sampled in setup so access never waits
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prdata_r <= 32'h00000000;
    end else if (setup) begin
      prdata_r <= i_apb.pwrite ? 32'h00000000 : {16'h0000, i_rd_data};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      err_r <= 1'b0;
    end else if (setup) begin
      err_r <= !i_hit;
    end
  end

  assign o_pready = i_apb.psel && i_apb.penable;
  assign o_pslverr = o_pready && err_r;
  assign o_prdata = prdata_r;

endmodule // fbms_apb_slave

// File: hw/fbms_addr_alloc.sv
`timescale 1ns/1ps
`include "fbms_consts.svh"

module fbms_addr_alloc #(
  parameter int STATIONS = `FBMS_STATIONS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // control
  input wire logic i_start,
  output logic o_busy,
  // station parameter lookup
  output logic [5:0] o_cfg_idx,
  input fbms_pkg::fbms_cfg_t i_cfg,
  // table write
  output fbms_pkg::fbms_tab_wr_t o_wr
);
  import fbms_pkg::*;

  logic busy_r;
  logic [5:0] idx_r;
  logic [15:0] in_ptr_r;
  logic [15:0] out_ptr_r;
  fbms_tab_wr_t wr_r;
  logic last;

  // bytes packed two per word, each station starting on a fresh word
  function automatic logic [15:0] words_of(input logic [7:0] len);
    words_of = {8'h00, len} + 16'h0001; // see R9
    words_of = {1'b0, words_of[15:1]};
  endfunction

  assign last = (idx_r == 6'(STATIONS - 1));
  assign o_cfg_idx = idx_r;
  assign o_busy = busy_r;
  assign o_wr = wr_r;

  // ==========================================================
  // walk stations in ascending number order, one per cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_r <= 1'b0;
    end else if (i_start) begin
      busy_r <= 1'b1;
    end else if (busy_r && last) begin
      busy_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_start) begin
      idx_r <= 6'h00;
      in_ptr_r <= 16'h0000;
      out_ptr_r <= `FBMS_OUT_AREA_BASE;
    end else if (busy_r && i_cfg.present) begin
      idx_r <= idx_r + 6'h01;
      // extended layout sizes each area by the configured byte length
      in_ptr_r <= in_ptr_r + words_of(i_cfg.in_len); // see R17
      out_ptr_r <= out_ptr_r + words_of(i_cfg.out_len);
    end else if (busy_r) begin
      idx_r <= idx_r + 6'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_r <= '0;
    end else begin
      wr_r.wr <= busy_r;
      wr_r.idx <= idx_r;
      wr_r.in_addr <= i_cfg.present ? in_ptr_r : 16'h0000;
      wr_r.out_addr <= i_cfg.present ? out_ptr_r : 16'h0000;
    end
  end

endmodule // fbms_addr_alloc

// File: hw/fbms_status_areas.sv
// Functional notes
// R1: station status kept in five host-readable words at 2112 to 2116.
// R2: extended service mode writes per-station input/output start addresses at 2128-2247.
// R3: normal service mode: every start-address table word reads zero.
// R4: table holds 60 input entries then 60 output entries, same station order.
// R5: start addresses are filled once at start-up, not during operation; a host request for extended mode refills them too.
// R6: start addresses count whole words from the head of each area.
// R7: entries follow configured parameter order, ascending station number.
// R8: changed slave parameters recompute the assignment, addresses may move.
// R9: two bytes per word, first byte low, each station starts a fresh word.
// R10: current operating mode reported in the word at 2254.
// R11: mode word written only in normal, parameter setting or extended mode.
// R12: mode word untouched in self-diagnosis or during nonvolatile-memory initialisation.
// R13: host-selected mode reads 0000h, 0001h or 000Eh.
// R14: mode started from nonvolatile memory reads 0100h, 0101h or 010Eh.
// R15: mode started from selector switch reads 1000h, 1001h or 100Eh.
// R16: a saved mode wins over a switch setting of normal, parameter or extended.
// R17: normal mode gives each station 32 bytes; extended uses configured lengths.
// R18: status, table and mode words are read-only; host writes do nothing.
`timescale 1ns/1ps
`include "fbms_consts.svh"

module fbms_status_areas #(
  parameter int STATIONS = `FBMS_STATIONS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // apb slave
  input fbms_pkg::fbms_apb_req_t i_apb,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // start-up and mode sources
  input wire logic i_startup,
  input wire logic [3:0] i_mode_switch,
  input wire logic i_nv_mode_valid,
  input wire logic [3:0] i_nv_mode,
  input wire logic i_nv_init_busy,
  input wire logic i_host_mode_req,
  input wire logic [3:0] i_host_mode,
  // slave parameters and status
  input wire logic i_param_changed,
  output logic [5:0] o_cfg_idx,
  input fbms_pkg::fbms_cfg_t i_cfg,
  input wire logic [79:0] i_station_status,
  // state seen by the rest of the module
  output logic [3:0] o_mode,
  output logic o_ready
);
  import fbms_pkg::*;

  typedef enum logic [1:0] {
    FBMS_ST_IDLE,
    FBMS_ST_DECIDE,
    FBMS_ST_ALLOC,
    FBMS_ST_RUN
  } fbms_state_t;

  fbms_state_t state_r;
  fbms_state_t state_nxt;
  logic [3:0] sw_meta_r;
  logic [3:0] sw_sync_r;
  logic [3:0] mode_r;
  logic [15:0] mode_word_r;
  logic [79:0] status_r;
  logic [15:0] in_tab_r [STATIONS];
  logic [15:0] out_tab_r [STATIONS];
  logic alloc_start;
  logic alloc_busy;
  logic params_dirty_r;
  fbms_tab_wr_t tab_wr;
  logic [13:0] word_idx;
  logic [15:0] rd_data;
  logic rd_hit;
  logic host_ok;
  logic [3:0] boot_mode;
  logic [7:0] boot_src;

  // ==========================================================
  // helpers
  function automatic logic svc_mode(input logic [3:0] m);
    svc_mode = (m == `FBMS_MODE_NORMAL) || (m == `FBMS_MODE_PARAM) || (m == `FBMS_MODE_EXTENDED);
  endfunction

  function automatic logic [15:0] mode_word(input logic [7:0] src, input logic [3:0] m);
    mode_word = {src, 4'h0, m};
  endfunction

  // ==========================================================
  // selector switch synchroniser
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sw_meta_r <= 4'h0;
      sw_sync_r <= 4'h0;
    end else begin
      sw_meta_r <= i_mode_switch;
      sw_sync_r <= sw_meta_r;
    end
  end

  // ==========================================================
  // start-up mode choice
  always_comb begin
    if (i_nv_mode_valid && svc_mode(sw_sync_r)) begin
      boot_mode = i_nv_mode; // see R16
      boot_src = `FBMS_SRC_NVMEM; // see R14
    end else begin
      boot_mode = sw_sync_r;
      boot_src = `FBMS_SRC_SWITCH; // see R15
    end
  end

  assign host_ok = i_host_mode_req && (state_r == FBMS_ST_RUN) && svc_mode(i_host_mode);

  // ==========================================================
  // start-up sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FBMS_ST_IDLE: begin
        if (i_startup) begin
          state_nxt = FBMS_ST_DECIDE;
        end
      end
      FBMS_ST_DECIDE: begin
        if (boot_mode == `FBMS_MODE_EXTENDED) begin
          state_nxt = FBMS_ST_ALLOC;
        end else begin
          state_nxt = FBMS_ST_RUN;
        end
      end
      FBMS_ST_ALLOC: begin
        if (!alloc_busy && !tab_wr.wr && !alloc_start) begin
          state_nxt = FBMS_ST_RUN;
        end
      end
      FBMS_ST_RUN: begin
        if (i_startup) begin
          state_nxt = FBMS_ST_DECIDE;
        end else if (host_ok && i_host_mode == `FBMS_MODE_EXTENDED) begin
          state_nxt = FBMS_ST_ALLOC;
        end
      end
      default: begin
        state_nxt = FBMS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= FBMS_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // allocation on the way into extended service at start-up, and again on a host request for extended mode while running, unless a start-up arrives with it
  assign alloc_start = (state_r != FBMS_ST_ALLOC) && (state_nxt == FBMS_ST_ALLOC); // see R5

  // ==========================================================
  // parameter change tracking
  // a change only marks the table stale; the new layout lands at the next allocation, at start-up or on a host extended request
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      params_dirty_r <= 1'b0;
    end else if (i_param_changed) begin
      params_dirty_r <= 1'b1; // see R8
    end else if (alloc_start) begin
      params_dirty_r <= 1'b0;
    end
  end

  // ==========================================================
  // operating mode
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_r <= `FBMS_MODE_NORMAL;
    end else if (state_r == FBMS_ST_DECIDE) begin
      mode_r <= boot_mode;
    end else if (host_ok) begin
      mode_r <= i_host_mode;
    end
  end

  // ==========================================================
  // current mode word
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_word_r <= `FBMS_MODE_WORD_RESET;
    end else if (i_nv_init_busy) begin
      mode_word_r <= mode_word_r; // see R12
    end else if (state_r == FBMS_ST_DECIDE && svc_mode(boot_mode)) begin
      mode_word_r <= mode_word(boot_src, boot_mode); // see R11
    end else if (host_ok) begin
      mode_word_r <= mode_word(`FBMS_SRC_HOST, i_host_mode); // see R13
    end
  end

  // ==========================================================
  // station status capture
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_r <= 80'h0;
    end else begin
      status_r <= i_station_status; // see R1
    end
  end

  // ==========================================================
  // start-address allocation
  fbms_addr_alloc #(
    .STATIONS(STATIONS)
  ) u_alloc (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(alloc_start),
    .o_busy(alloc_busy),
    .o_cfg_idx(o_cfg_idx),
    .i_cfg(i_cfg),
    .o_wr(tab_wr)
  );

  // entries are indexed by station, inputs and outputs in the same order
  always_ff @(posedge i_clk) begin
    if (tab_wr.wr) begin
      in_tab_r[tab_wr.idx] <= tab_wr.in_addr; // see R2, R4, R6, R7
      out_tab_r[tab_wr.idx] <= tab_wr.out_addr; // see R2, R4, R6, R7
    end
  end

  // ==========================================================
  // register read decode
  // no write path exists, so a host write cannot touch any state
  always_comb begin
    rd_data = 16'h0000;
    rd_hit = 1'b1;
    if (word_idx >= `FBMS_IDX_STATUS_LO && word_idx <= `FBMS_IDX_STATUS_HI) begin
      rd_data = status_r[16 * (word_idx - `FBMS_IDX_STATUS_LO) +: 16]; // see R1
    end else if (word_idx >= `FBMS_IDX_IN_TAB_LO && word_idx < `FBMS_IDX_OUT_TAB_LO) begin
      if (mode_r == `FBMS_MODE_EXTENDED && state_r == FBMS_ST_RUN) begin
        rd_data = in_tab_r[6'(word_idx - `FBMS_IDX_IN_TAB_LO)];
      end else begin
        rd_data = 16'h0000; // see R3
      end
    end else if (word_idx >= `FBMS_IDX_OUT_TAB_LO && word_idx <= `FBMS_IDX_TAB_HI) begin
      if (mode_r == `FBMS_MODE_EXTENDED && state_r == FBMS_ST_RUN) begin
        rd_data = out_tab_r[6'(word_idx - `FBMS_IDX_OUT_TAB_LO)];
      end else begin
        rd_data = 16'h0000; // see R3
      end
    end else if (word_idx == `FBMS_IDX_MODE) begin
      rd_data = mode_word_r; // see R10
    end else begin
      rd_hit = 1'b0;
    end
  end

  fbms_apb_slave u_apb (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_apb(i_apb),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_prdata(o_prdata),
    .o_word_idx(word_idx),
    .i_rd_data(rd_data),
    .i_hit(rd_hit) // see R18
  );

  // ==========================================================
  // status outputs
  assign o_mode = mode_r;
  assign o_ready = (state_r == FBMS_ST_RUN);

endmodule // fbms_status_areas

// File: bench/fbms_cfg_model.sv
`timescale 1ns/1ps

// ==========
// slave parameter store seen by the allocator
module fbms_cfg_model (
  // lookup
  input wire logic [5:0] i_idx,
  input fbms_pkg::fbms_cfg_t i_tab [4],
  output fbms_pkg::fbms_cfg_t o_cfg
);
  import fbms_pkg::*;
  // answer in the same cycle; stations past the table are unconfigured
  assign o_cfg = (i_idx < 6'd4) ? i_tab[i_idx[1:0]] : '0;
endmodule // fbms_cfg_model

// File: bench/fbms_status_areas_sva.sv
`timescale 1ns/1ps
`include "fbms_consts.svh"

// ==========
// port checker
module fbms_status_areas_chk #(
  parameter int STATIONS = 60
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input fbms_pkg::fbms_apb_req_t i_apb,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [31:0] o_prdata,
  input wire logic i_startup,
  input wire logic [3:0] i_mode_switch,
  input wire logic i_nv_mode_valid,
  input wire logic [3:0] i_nv_mode,
  input wire logic i_nv_init_busy,
  input wire logic [5:0] o_cfg_idx,
  input wire logic [3:0] o_mode,
  input wire logic o_ready
);
  import fbms_pkg::*;
  logic su;
  logic [13:0] ix;
  assign su = i_apb.psel && !i_apb.penable;
  assign ix = i_apb.paddr[15:2];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_pready_zero_wait: assert property (o_pready == (i_apb.psel && i_apb.penable))
    else $error("pready not tied to access phase");
  a_err_in_access: assert property (o_pslverr |-> o_pready) else $error("pslverr outside access");
  a_unmapped_err: assert property (su && ix == 14'h845 |=> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped word not refused");
  a_write_no_data: assert property (su && i_apb.pwrite |=> o_prdata == 32'h0) else $error("write returned data");
  a_table_zero: assert property (su && ix >= `FBMS_IDX_IN_TAB_LO && ix <= `FBMS_IDX_TAB_HI
    && o_mode != `FBMS_MODE_EXTENDED |=> o_prdata == 32'h0) else $error("table nonzero outside extended");
  a_start_drops: assert property (i_startup |=> !o_ready) else $error("ready kept over start-up");
  a_alloc_step: assert property (!o_ready && o_cfg_idx != 6'h0 && o_cfg_idx < 6'(STATIONS - 1)
    |=> o_cfg_idx == $past(o_cfg_idx) + 6'h1) else $error("allocator skipped a station");
  a_switch_src: assert property (i_startup && !i_nv_mode_valid && !i_nv_init_busy
    && i_mode_switch == $past(i_mode_switch, 3) && i_mode_switch inside {4'h0, 4'h1, 4'he}
    |-> ##2 o_mode == $past(i_mode_switch, 2)) else $error("switch mode not taken");
  a_saved_wins: assert property (i_startup && i_nv_mode_valid && !i_nv_init_busy
    && i_mode_switch == $past(i_mode_switch, 3) && i_mode_switch inside {4'h0, 4'h1, 4'he}
    && i_nv_mode inside {4'h0, 4'h1, 4'he} |-> ##2 o_mode == $past(i_nv_mode, 2)) else $error("saved mode lost");
  c_refused: cover property (o_pslverr);
  c_alloc_end: cover property (!o_ready && o_cfg_idx == 6'(STATIONS - 1));
  c_ext_run: cover property (o_ready && o_mode == `FBMS_MODE_EXTENDED);
endmodule // fbms_status_areas_chk

bind fbms_status_areas fbms_status_areas_chk #(.STATIONS(STATIONS)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_apb(i_apb), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata), .i_startup(i_startup),
  .i_mode_switch(i_mode_switch), .i_nv_mode_valid(i_nv_mode_valid), .i_nv_mode(i_nv_mode),
  .i_nv_init_busy(i_nv_init_busy), .o_cfg_idx(o_cfg_idx), .o_mode(o_mode), .o_ready(o_ready));

// File: bench/fbms_status_areas_tb_top.sv
`timescale 1ns/1ps
`include "fbms_consts.svh"

// ==========
// bench top
module fbms_status_areas_tb_top;
  import fbms_pkg::*;
  logic i_clk = 0, i_rst = 1, i_startup = 0, i_nv_mode_valid = 0, i_nv_init_busy = 0;
  logic i_host_mode_req = 0, i_param_changed = 0, o_pready, o_pslverr, o_ready;
  logic [3:0] i_mode_switch = 0, i_nv_mode = 0, i_host_mode = 0, o_mode;
  logic [79:0] i_station_status = 0;
  logic [31:0] o_prdata, rs = 32'd13556;
  logic [5:0] o_cfg_idx;
  logic [3:0] codes [3] = '{4'h0, 4'h1, 4'he};
  logic [32:0] expq [$];
  fbms_apb_req_t apb = '0;
  fbms_cfg_t cfg, mdl [4], tab [4];
  int miscompares = 0, check_count = 0;

  fbms_status_areas i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_apb(apb), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_prdata(o_prdata), .i_startup(i_startup), .i_mode_switch(i_mode_switch), .i_nv_mode_valid(i_nv_mode_valid),
    .i_nv_mode(i_nv_mode), .i_nv_init_busy(i_nv_init_busy), .i_host_mode_req(i_host_mode_req),
    .i_host_mode(i_host_mode), .i_param_changed(i_param_changed), .o_cfg_idx(o_cfg_idx), .i_cfg(cfg),
    .i_station_status(i_station_status), .o_mode(o_mode), .o_ready(o_ready));
  fbms_cfg_model i_mdl (.i_idx(o_cfg_idx), .i_tab(mdl), .o_cfg(cfg));

  initial forever #12.5 i_clk = ~i_clk;

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // word count of the present stations ahead of k, from the head of each area
  function automatic logic [15:0] start_of(int k, bit out);
    logic [15:0] a;
    a = out ? `FBMS_OUT_AREA_BASE : 16'h0;
    if (k > 3 || !tab[k].present) return 16'h0;
    for (int j = 0; j < k; j++) if (tab[j].present) a += 16'((out ? tab[j].out_len : tab[j].in_len) + 9'd1) >> 1;
    return a;
  endfunction

  task automatic cmp(string nm, logic [32:0] e, logic [32:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic xfer(logic [13:0] ix, logic w, logic [31:0] d);
    apb.psel <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite <= w;
    apb.paddr <= {ix, 2'b00};
    apb.pwdata <= d;
    @(posedge i_clk);
    apb.penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rd(logic [13:0] ix, logic [32:0] e);
    expq.push_back(e);
    xfer(ix, 1'b0, 32'h0);
  endtask

  always @(posedge i_clk) if (apb.psel && apb.penable && o_pready === 1'b1 && !apb.pwrite)
    cmp("prdata", expq.pop_front(), {o_pslverr, o_prdata});

  task automatic wait_rdy();
    for (int n = 0; n < 200 && o_ready !== 1'b1; n++) @(posedge i_clk);
    cmp("o_ready", 33'h1, {32'h0, o_ready});
  endtask

  task automatic start_up(logic [3:0] sw, logic nvv, logic [3:0] nv, bit wt);
    i_mode_switch <= sw;
    i_nv_mode_valid <= nvv;
    i_nv_mode <= nv;
    repeat (4) @(posedge i_clk);
    i_startup <= 1'b1;
    @(posedge i_clk);
    i_startup <= 1'b0;
    @(posedge i_clk);
    if (wt) wait_rdy();
  endtask

  task automatic host_req(logic [3:0] c);
    i_host_mode <= c;
    i_host_mode_req <= 1'b1;
    @(posedge i_clk);
    i_host_mode_req <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic chk_tab(bit ext);
    for (int k = 0; k < 5; k++) begin
      rd(`FBMS_IDX_IN_TAB_LO + 14'(k), {17'h0, (ext ? start_of(k, 0) : 16'h0)});
      rd(`FBMS_IDX_OUT_TAB_LO + 14'(k), {17'h0, (ext ? start_of(k, 1) : 16'h0)});
    end
    rd(`FBMS_IDX_TAB_HI, 33'h0);
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    wrap_up();
  end

  // ==========
  // main sequence
  initial begin
    for (int k = 0; k < 4; k++) begin
      rs = xs(rs);
      mdl[k].present = (k != 1);
      mdl[k].in_len = 8'(rs[4:0]) + 8'h1;
      mdl[k].out_len = 8'(rs[12:8]) + 8'h1;
    end
    tab = mdl;
    rs = xs(rs);
    i_station_status = {rs[15:0], rs, xs(rs)};
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    start_up(4'h0, 1'b0, 4'h0, 1'b1);
    for (int n = 0; n < 5; n++) rd(`FBMS_IDX_STATUS_LO + 14'(n), {17'h0, i_station_status[16*n +: 16]});
    rd(14'h845, {1'b1, 32'h0});
    xfer(`FBMS_IDX_MODE, 1'b1, 32'hffff);
    rd(`FBMS_IDX_MODE, 33'h1000);
    for (int i = 0; i < 3; i++) begin
      start_up(codes[i], 1'b0, 4'h0, 1'b1);
      rd(`FBMS_IDX_MODE, {17'h0, 12'h100, codes[i]});
      chk_tab(codes[i] == `FBMS_MODE_EXTENDED);
    end
    // new layout stays unseen until the next start-up
    mdl[1].present = 1'b1;
    i_param_changed <= 1'b1;
    @(posedge i_clk);
    i_param_changed <= 1'b0;
    @(posedge i_clk);
    chk_tab(1'b1);
    start_up(4'he, 1'b0, 4'h0, 1'b1);
    tab = mdl;
    chk_tab(1'b1);
    for (int i = 0; i < 3; i++) begin
      start_up(4'h1, 1'b1, codes[i], 1'b1);
      rd(`FBMS_IDX_MODE, {17'h0, 12'h010, codes[i]});
    end
    for (int i = 0; i < 3; i++) begin
      host_req(codes[(i + 2) % 3]);
      wait_rdy();
      rd(`FBMS_IDX_MODE, {29'h0, codes[(i + 2) % 3]});
    end
    host_req(4'h2);
    rd(`FBMS_IDX_MODE, 33'h1);
    i_nv_init_busy <= 1'b1;
    host_req(4'h0);
    rd(`FBMS_IDX_MODE, 33'h1);
    i_nv_init_busy <= 1'b0;
    start_up(4'h2, 1'b0, 4'h0, 1'b0);
    repeat (80) @(posedge i_clk);
    rd(`FBMS_IDX_MODE, 33'h1);
    wrap_up();
  end
endmodule // fbms_status_areas_tb_top
